/* src/gpt_consts.svh */
// Constants for the general-purpose timer block
// Behaviour
// R01: Reset sets counters and load registers to ones
// R02: Reset clears prescale counters and prescale registers
// R03: After reset block idle, control registers default
// R04: Configuration 0 one-shot/periodic, 1 real-time clock
// R05: 32-bit load write splits into both halves
// R06: 32-bit count read joins both halves
// R07: 32-bit mode single timer; 16-bit halves independent
// R08: 32-bit mode uses first mode field only
// R09: Enabled timer counts down, reloads after zero
// R10: One-shot stops and clears enable; periodic continues
// R11: Zero sets raw timeout flag and trigger
// R12: Unmasked timeout also sets masked flag
// R13: Load write while running reloads next cycle
// R14: Debug stall bit freezes counting during halt
// R15: Real-time clock first selection loads one
// R16: Later real-time loads come from match register
// R17: Outside supplies 32.768 kHz on even pin
// R18: Divide input to 1 Hz, count per tick
// R19: Match rolls counter to zero, keeps counting
// R20: Match sets raw flag, masked flag, interrupt
// R21: Clear bit write clears real-time flags
// R22: Clock stall enable overrides both debug stalls; the code overrides only the first stall, in real-time clock mode
// R23: Real-time input synchronised and edge detected
// R24: Configuration 4 selects independent 16-bit halves
`ifndef GPT_CONSTS_SVH
`define GPT_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define GPT_OFF_CFG 8'h00
`define GPT_OFF_MODE_A 8'h04
`define GPT_OFF_MODE_B 8'h08
`define GPT_OFF_CTL 8'h0C
`define GPT_OFF_IMR 8'h18
`define GPT_OFF_RIS 8'h1C
`define GPT_OFF_MIS 8'h20
`define GPT_OFF_ICR 8'h24
`define GPT_OFF_ILR_A 8'h28
`define GPT_OFF_ILR_B 8'h2C
`define GPT_OFF_MATCH 8'h30
`define GPT_OFF_PR_A 8'h38
`define GPT_OFF_PR_B 8'h3C
`define GPT_OFF_CNT_A 8'h48
`define GPT_OFF_CNT_B 8'h4C

// ****************************************************************
// Field values and bit positions
// ****************************************************************
`define GPT_CFG_32T 3'h0
`define GPT_CFG_RTC 3'h1
`define GPT_CFG_16 3'h4
`define GPT_MODE_ONESHOT 2'h1
`define GPT_MODE_PERIODIC 2'h2
`define GPT_CTL_EN_A 0
`define GPT_CTL_STALL_A 1
`define GPT_CTL_CLK_STALL 4
`define GPT_CTL_EN_B 8
`define GPT_CTL_STALL_B 9
`define GPT_ST_TO_A 0
`define GPT_ST_RTC 3
`define GPT_ST_TO_B 8

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define GPT_CNT_RST 16'hFFFF
`define GPT_PR_RST 8'h00
`define GPT_ZERO16 16'h0000
`define GPT_ZERO32 32'h0000_0000
`define GPT_RTC_START 32'h0000_0001
`define GPT_RTC_IN_HZ 32768
`define GPT_RTC_TICK_HZ 1
`define GPT_RTC_DIV (`GPT_RTC_IN_HZ / `GPT_RTC_TICK_HZ)
`define GPT_DIV_W 16

`endif

/* src/gpt_pkg.sv */
// Types shared by the timer modules
package gpt_pkg;

  typedef struct packed {
    logic [2:0] cfg;
    logic [3:0] mode_a;
    logic [3:0] mode_b;
    logic en_a;
    logic stall_a;
    logic clk_stall;
    logic en_b;
    logic stall_b;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [15:0] ilr_a;
    logic [15:0] ilr_b;
    logic [31:0] match;
    logic [7:0] pr_a;
    logic [7:0] pr_b;
    logic [7:0] pc_a;
    logic [7:0] pc_b;
    logic [2:0] imr;
    logic [2:0] ris;
    logic rtc_loaded;
    logic ack;
    logic [31:0] dat;
    logic trig_a;
    logic trig_b;
  } gpt_state_s;

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic [15:0] cnt;
    logic tick;
  } gpt_div_s;

endpackage

/* src/gpt_rtc_div.sv */
// Real-time clock input synchroniser and divide-to-tick prescaler
`timescale 1ns/1ns
`default_nettype none
`include "gpt_consts.svh"

module gpt_rtc_div #(
  parameter int DIV = `GPT_RTC_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic run,
  output logic tick
);

  // Counter width is fixed by the state record
  if (DIV < 2 || DIV > (1 << `GPT_DIV_W))
  begin : g_chk
    $error("gpt_rtc_div: DIV out of range");
  end

  localparam logic [15:0] LAST = 16'(DIV - 1);

  gpt_pkg::gpt_div_s r;
  gpt_pkg::gpt_div_s next_r;
  logic rise;

  // ****************************************************************
  // Synchronise, filter, divide
  // ****************************************************************
  // Level accepted only when stages two and three agree
  always_comb
  begin
    next_r = r;
    next_r.sync = {r.sync[1:0], pin}; // R23
    rise = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.lvl; // R23
    if (r.sync[1] == r.sync[2])
    begin
      next_r.lvl = r.sync[2];
    end
    next_r.tick = 1'b0;
    // Divider parks while the counter is off or frozen
    if (!run)
    begin
      next_r.cnt = `GPT_ZERO16;
    end
    else if (rise)
    begin
      if (r.cnt == LAST)
      begin
        next_r.cnt = `GPT_ZERO16;
        next_r.tick = 1'b1; // R18
      end
      else
      begin
        next_r.cnt = r.cnt + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule
`default_nettype wire

/* src/gpt_top.sv */
// General-purpose timer: 32-bit timer, real-time clock, 16-bit halves
`timescale 1ns/1ns
`default_nettype none
`include "gpt_consts.svh"

module gpt_top #(
  parameter int RTC_DIV = `GPT_RTC_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_pin_even_t0,
  input wire logic debug_halt,
  output logic irq,
  output logic first_timeout_trigger,
  output logic second_timeout_trigger
);

  gpt_pkg::gpt_state_s r;
  gpt_pkg::gpt_state_s next_r;
  logic rtc_tick;
  logic rtc_run;
  logic frozen_a;
  logic frozen_b;
  logic wr;
  logic [31:0] cur_cnt;
  logic [31:0] cur_ilr;
  logic is32;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        v[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // Internal flag triple to register bit layout
  function automatic logic [31:0] expand(input logic [2:0] s);
    logic [31:0] v;
    v = '0;
    v[`GPT_ST_TO_A] = s[0];
    v[`GPT_ST_TO_B] = s[1];
    v[`GPT_ST_RTC] = s[2];
    return v;
  endfunction

  function automatic logic [2:0] compress(input logic [31:0] w);
    return {w[`GPT_ST_RTC], w[`GPT_ST_TO_B], w[`GPT_ST_TO_A]};
  endfunction

  // Only one-shot and periodic run; other mode codes hold still
  function automatic logic counts(input logic [3:0] m);
    return (m[1:0] == `GPT_MODE_ONESHOT) || (m[1:0] == `GPT_MODE_PERIODIC);
  endfunction

  // One 16-bit step with prescaler: returns {timeout, pc, cnt}
  function automatic logic [24:0] half_step(input logic [15:0] cnt,
                                            input logic [15:0] ilr,
                                            input logic [7:0] pc,
                                            input logic [7:0] pr);
    logic [24:0] v;
    v = {1'b0, pc, cnt};
    if (pc != `GPT_PR_RST)
    begin
      v[23:16] = pc - 8'h01;
    end
    else
    begin
      v[23:16] = pr;
      if (cnt == `GPT_ZERO16)
      begin
        v = {1'b1, pr, ilr};
      end
      else
      begin
        v[15:0] = cnt - 16'h0001;
      end
    end
    return v;
  endfunction

  // ****************************************************************
  // Real-time clock input
  // ****************************************************************
  // Debug halt is a same-clock signal from the core, so no synchroniser
  assign is32 = (r.cfg == `GPT_CFG_32T) || (r.cfg == `GPT_CFG_RTC);
  assign frozen_a = debug_halt && r.stall_a
                    && !(r.cfg == `GPT_CFG_RTC && r.clk_stall); // R14 R22
  assign frozen_b = debug_halt && r.stall_b;
  assign rtc_run = (r.cfg == `GPT_CFG_RTC) && r.en_a && !frozen_a;
  assign cur_cnt = {r.cnt_b, r.cnt_a};
  assign cur_ilr = {r.ilr_b, r.ilr_a};
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && r.ack;

  gpt_rtc_div #(
    .DIV(RTC_DIV)
  ) i_gpt_rtc_div (
    .clk(clk),
    .rst(rst),
    .pin(capture_pin_even_t0),
    .run(rtc_run),
    .tick(rtc_tick)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [31:0] n32;
    logic [31:0] w;
    logic [31:0] rd;
    logic [24:0] sa;
    logic [24:0] sb;
    logic [2:0] set_st;
    logic [2:0] clr_st;
    n32 = cur_cnt;
    w = '0;
    rd = '0;
    sa = '0;
    sb = '0;
    set_st = 3'h0;
    clr_st = 3'h0;
    next_r = r;
    next_r.trig_a = 1'b0;
    next_r.trig_b = 1'b0;
    // Ack one cycle after the request, dropped the cycle after
    next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;

    // Counting per configuration
    case (r.cfg)
      `GPT_CFG_32T:
      begin
        if (r.en_a && !frozen_a && counts(r.mode_a)) // R08 R14
        begin
          if (cur_cnt == `GPT_ZERO32)
          begin
            n32 = cur_ilr; // R09
            set_st[0] = 1'b1; // R11
            next_r.trig_a = 1'b1; // R11
            if (r.mode_a[1:0] == `GPT_MODE_ONESHOT)
            begin
              next_r.en_a = 1'b0; // R10
            end
          end
          else
          begin
            n32 = cur_cnt - 32'h0000_0001; // R09
          end
        end
      end
      `GPT_CFG_RTC:
      begin
        if (rtc_run && rtc_tick) // R18
        begin
          if (cur_cnt == r.match)
          begin
            n32 = `GPT_ZERO32; // R19
            set_st[2] = 1'b1; // R20
          end
          else
          begin
            n32 = cur_cnt + 32'h0000_0001; // R19
          end
        end
      end
      `GPT_CFG_16:
      begin
        // Each half runs on its own mode, enable and stall
        sa = half_step(r.cnt_a, r.ilr_a, r.pc_a, r.pr_a);
        sb = half_step(r.cnt_b, r.ilr_b, r.pc_b, r.pr_b);
        if (r.en_a && !frozen_a && counts(r.mode_a)) // R07
        begin
          {set_st[0], next_r.pc_a, n32[15:0]} = sa;
          next_r.trig_a = sa[24];
          if (sa[24] && r.mode_a[1:0] == `GPT_MODE_ONESHOT)
          begin
            next_r.en_a = 1'b0;
          end
        end
        if (r.en_b && !frozen_b && counts(r.mode_b)) // R07
        begin
          {set_st[1], next_r.pc_b, n32[31:16]} = sb;
          next_r.trig_b = sb[24];
          if (sb[24] && r.mode_b[1:0] == `GPT_MODE_ONESHOT)
          begin
            next_r.en_b = 1'b0;
          end
        end
      end
      default:
      begin
        n32 = cur_cnt;
      end
    endcase

    // Register writes land at the acknowledging edge; all but a flag clear win over counting
    if (wr)
    begin
      case (wb_adr_i)
        `GPT_OFF_CFG:
        begin
          w = merge(32'(r.cfg), wb_dat_i, wb_sel_i);
          next_r.cfg = w[2:0]; // R04 R24
          if (w[2:0] == `GPT_CFG_RTC)
          begin
            n32 = r.rtc_loaded ? r.match : `GPT_RTC_START; // R15 R16
            next_r.rtc_loaded = 1'b1;
          end
        end
        `GPT_OFF_MODE_A:
        begin
          w = merge(32'(r.mode_a), wb_dat_i, wb_sel_i);
          next_r.mode_a = w[3:0];
        end
        `GPT_OFF_MODE_B:
        begin
          w = merge(32'(r.mode_b), wb_dat_i, wb_sel_i);
          next_r.mode_b = w[3:0];
        end
        `GPT_OFF_CTL:
        begin
          w = merge('0, wb_dat_i, wb_sel_i);
          next_r.en_a = w[`GPT_CTL_EN_A];
          next_r.stall_a = w[`GPT_CTL_STALL_A];
          next_r.clk_stall = w[`GPT_CTL_CLK_STALL];
          next_r.en_b = w[`GPT_CTL_EN_B];
          next_r.stall_b = w[`GPT_CTL_STALL_B];
        end
        `GPT_OFF_IMR:
        begin
          w = merge(expand(r.imr), wb_dat_i, wb_sel_i);
          next_r.imr = compress(w);
        end
        `GPT_OFF_ICR:
        begin
          clr_st = compress(merge('0, wb_dat_i, wb_sel_i)); // R21
        end
        `GPT_OFF_ILR_A:
        begin
          w = merge(is32 ? cur_ilr : 32'(r.ilr_a), wb_dat_i, wb_sel_i);
          if (is32)
          begin
            {next_r.ilr_b, next_r.ilr_a} = w; // R05
            n32 = w; // R13
          end
          else
          begin
            next_r.ilr_a = w[15:0];
            n32[15:0] = w[15:0]; // R13
          end
        end
        `GPT_OFF_ILR_B:
        begin
          w = merge(32'(r.ilr_b), wb_dat_i, wb_sel_i);
          next_r.ilr_b = w[15:0];
          n32[31:16] = w[15:0];
        end
        `GPT_OFF_MATCH:
        begin
          next_r.match = merge(r.match, wb_dat_i, wb_sel_i); // R16
        end
        `GPT_OFF_PR_A:
        begin
          w = merge(32'(r.pr_a), wb_dat_i, wb_sel_i);
          next_r.pr_a = w[7:0];
        end
        `GPT_OFF_PR_B:
        begin
          w = merge(32'(r.pr_b), wb_dat_i, wb_sel_i);
          next_r.pr_b = w[7:0];
        end
        default:
        begin
          w = '0;
        end
      endcase
    end
    {next_r.cnt_b, next_r.cnt_a} = n32;
    // A flag event in the clearing cycle survives the clear
    next_r.ris = (r.ris & ~clr_st) | set_st; // R11 R20 R21

    // Read data captured with the ack; unmapped reads give zero
    case (wb_adr_i)
      `GPT_OFF_CFG: rd = 32'(r.cfg);
      `GPT_OFF_MODE_A: rd = 32'(r.mode_a);
      `GPT_OFF_MODE_B: rd = 32'(r.mode_b);
      `GPT_OFF_CTL:
      begin
        rd[`GPT_CTL_EN_A] = r.en_a;
        rd[`GPT_CTL_STALL_A] = r.stall_a;
        rd[`GPT_CTL_CLK_STALL] = r.clk_stall;
        rd[`GPT_CTL_EN_B] = r.en_b;
        rd[`GPT_CTL_STALL_B] = r.stall_b;
      end
      `GPT_OFF_IMR: rd = expand(r.imr);
      `GPT_OFF_RIS: rd = expand(r.ris);
      `GPT_OFF_MIS: rd = expand(r.ris & r.imr); // R12 R20
      `GPT_OFF_ILR_A: rd = is32 ? cur_ilr : 32'(r.ilr_a);
      `GPT_OFF_ILR_B: rd = 32'(r.ilr_b);
      `GPT_OFF_MATCH: rd = r.match;
      `GPT_OFF_PR_A: rd = 32'(r.pr_a);
      `GPT_OFF_PR_B: rd = 32'(r.pr_b);
      `GPT_OFF_CNT_A: rd = is32 ? cur_cnt : 32'(r.cnt_a); // R06
      `GPT_OFF_CNT_B: rd = 32'(r.cnt_b);
      default: rd = '0;
    endcase
    if (next_r.ack && !wb_we_i)
    begin
      next_r.dat = rd;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Everything idles at reset except the all-ones counters and loads
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0; // R02 R03
      r.cnt_a <= `GPT_CNT_RST; // R01
      r.cnt_b <= `GPT_CNT_RST; // R01
      r.ilr_a <= `GPT_CNT_RST; // R01
      r.ilr_b <= `GPT_CNT_RST; // R01
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign irq = |(r.ris & r.imr); // R20
  assign first_timeout_trigger = r.trig_a;
  assign second_timeout_trigger = r.trig_b;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rst_ones;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> cur_cnt == {`GPT_CNT_RST, `GPT_CNT_RST}
                   && cur_ilr == {`GPT_CNT_RST, `GPT_CNT_RST};
  endproperty
  a_rst_ones: assert property (p_rst_ones) // R01
    else $error("counters or loads not all ones after reset");

  property p_rst_pre;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> r.pc_a == `GPT_PR_RST && r.pc_b == `GPT_PR_RST
                   && r.pr_a == `GPT_PR_RST && r.pr_b == `GPT_PR_RST;
  endproperty
  a_rst_pre: assert property (p_rst_pre) // R02
    else $error("prescale not cleared after reset");

  property p_rst_idle;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> !r.en_a && !r.en_b && r.cfg == `GPT_CFG_32T && !irq
                   ##1 $stable(cur_cnt);
  endproperty
  a_rst_idle: assert property (p_rst_idle) // R03
    else $error("block not idle after reset");

  property p_oneshot;
    @(posedge clk) disable iff (rst)
    (r.cfg == `GPT_CFG_32T && r.en_a && !frozen_a && !wr
     && r.mode_a[1:0] == `GPT_MODE_ONESHOT && cur_cnt == `GPT_ZERO32)
    |=> !r.en_a && cur_cnt == $past(cur_ilr);
  endproperty
  a_oneshot: assert property (p_oneshot) // R10
    else $error("one-shot did not reload and stop");

  property p_timeout;
    @(posedge clk) disable iff (rst)
    (r.cfg == `GPT_CFG_32T && r.en_a && !frozen_a && counts(r.mode_a)
     && cur_cnt == `GPT_ZERO32)
    |=> r.ris[0] && first_timeout_trigger ##1 !first_timeout_trigger;
  endproperty
  a_timeout: assert property (p_timeout) // R11
    else $error("timeout flag or trigger missing");

  property p_masked;
    @(posedge clk) disable iff (rst)
    (r.ris[0] && r.imr[0]) || (r.ris[2] && r.imr[2]) |-> irq;
  endproperty
  a_masked: assert property (p_masked) // R12
    else $error("unmasked flag did not raise interrupt");

  property p_reload;
    @(posedge clk) disable iff (rst)
    (wr && wb_adr_i == `GPT_OFF_ILR_A && wb_sel_i == 4'hF
     && r.cfg == `GPT_CFG_32T) |=> cur_cnt == $past(wb_dat_i);
  endproperty
  a_reload: assert property (p_reload) // R13
    else $error("load write not taken by counter");

  property p_stall;
    @(posedge clk) disable iff (rst)
    (r.cfg == `GPT_CFG_32T && frozen_a && !wr) |=> $stable(cur_cnt);
  endproperty
  a_stall: assert property (p_stall) // R14
    else $error("counter moved during debug stall");

  property p_rtc_first;
    @(posedge clk) disable iff (rst)
    (wr && wb_adr_i == `GPT_OFF_CFG && wb_sel_i[0] && !r.rtc_loaded
     && wb_dat_i[2:0] == `GPT_CFG_RTC) |=> cur_cnt == `GPT_RTC_START;
  endproperty
  a_rtc_first: assert property (p_rtc_first) // R15
    else $error("first clock selection did not load one");

  property p_rtc_roll;
    @(posedge clk) disable iff (rst)
    (rtc_run && rtc_tick && cur_cnt == r.match && !wr)
    |=> cur_cnt == `GPT_ZERO32 && r.ris[2];
  endproperty
  a_rtc_roll: assert property (p_rtc_roll) // R19
    else $error("clock match did not roll over and flag");

endmodule
`default_nettype wire

/* testbench/gpt_rtc_src.sv */
// Slow real-time clock source standing in front of the even capture pin
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Clock source
// ****************************************************************
module gpt_rtc_src (
  input wire logic clk,
  input wire logic run,
  output logic pin
);
  logic [1:0] ph = 2'h0;
  logic lvl = 1'b0;

  // Toggle every fourth clock; stands still while not running
  // Scaled down from the slow crystal so a run stays short
  // One process owns the level so the pin has a single driver
  always @(posedge clk)
  begin
    if (run)
    begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
        lvl <= ~lvl;
    end
  end
  assign pin = lvl;
endmodule
`default_nettype wire

/* testbench/gpt_top_tb.sv */
// Self-checking testbench of the timer block over Wishbone
`timescale 1ns/1ns
`default_nettype none
`include "gpt_consts.svh"

module gpt_top_tb;
  logic clk, rst, cyc, stb, we, halt, run;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, v;
  logic ack, irq, trig_a, trig_b, pin;
  int errors = 0;
  int n_compared = 0;
  int n;

  gpt_top #(.RTC_DIV(4)) i_gpt_top (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .capture_pin_even_t0(pin), .debug_halt(halt), .irq(irq),
    .first_timeout_trigger(trig_a), .second_timeout_trigger(trig_b));
  gpt_rtc_src i_gpt_rtc_src (.clk(clk), .run(run), .pin(pin));

  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; ack and read data taken at the same rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1)
    begin
      errors++;
      complete_run;
    end
    else
    begin
      v = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(v, exp);
  endtask

  // Counts cycles until a trigger or irq shows, bounded
  task wait_for(input int which, input int limit);
    logic hit;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      hit = which == 0 ? trig_a : which == 1 ? trig_b : irq;
    end
    while (hit !== 1'b1 && n < limit);
    if (hit !== 1'b1)
    begin
      errors++;
      complete_run;
    end
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, halt, run} = 5'h00;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`GPT_OFF_CNT_A, 32'hFFFF_FFFF);
    rd_chk(`GPT_OFF_ILR_A, 32'hFFFF_FFFF);
    rd_chk(`GPT_OFF_PR_A, 32'h0000_0000);
    rd_chk(`GPT_OFF_PR_B, 32'h0000_0000);
    rd_chk(`GPT_OFF_CTL, 32'h0000_0000);
    rd_chk(`GPT_OFF_RIS, 32'h0000_0000);
    rd_chk(8'h70, 32'h0000_0000);
    $display("test reset done");
    // One-shot, second mode set to periodic must be ignored
    wb(1'b1, `GPT_OFF_CFG, 32'h0000_0000);
    wb(1'b1, `GPT_OFF_MODE_A, 32'h0000_0001);
    wb(1'b1, `GPT_OFF_MODE_B, 32'h0000_0002);
    wb(1'b1, `GPT_OFF_IMR, 32'h0000_0001);
    wb(1'b1, `GPT_OFF_ILR_A, 32'h0001_0000);
    rd_chk(`GPT_OFF_ILR_B, 32'h0000_0001);
    rd_chk(`GPT_OFF_CNT_A, 32'h0001_0000);
    wb(1'b1, `GPT_OFF_CTL, 32'h0000_0001);
    wb(1'b0, `GPT_OFF_CNT_A, 32'h0000_0000);
    check(32'(v[31:16]), 32'h0000_0000);
    wb(1'b1, `GPT_OFF_ILR_A, 32'h0000_0020);
    wait_for(0, 60);
    check(32'(n >= 32 && n <= 36), 32'h0000_0001);
    rd_chk(`GPT_OFF_CTL, 32'h0000_0000);
    rd_chk(`GPT_OFF_RIS, 32'h0000_0001);
    rd_chk(`GPT_OFF_MIS, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wb(1'b1, `GPT_OFF_ICR, 32'h0000_0001);
    rd_chk(`GPT_OFF_RIS, 32'h0000_0000);
    $display("test one-shot done");
    // Periodic, frozen while halted
    wb(1'b1, `GPT_OFF_MODE_A, 32'h0000_0002);
    halt <= 1'b1;
    wb(1'b1, `GPT_OFF_ILR_A, 32'h0000_0040);
    wb(1'b1, `GPT_OFF_CTL, 32'h0000_0003);
    repeat (10) @(posedge clk);
    rd_chk(`GPT_OFF_CNT_A, 32'h0000_0040);
    halt <= 1'b0;
    wait_for(0, 200);
    wait_for(0, 200);
    check(32'(n), 32'h0000_0041);
    rd_chk(`GPT_OFF_CTL, 32'h0000_0003);
    wb(1'b1, `GPT_OFF_CTL, 32'h0000_0000);
    $display("test periodic done");
    // Real-time clock, halted with clock stall enable set
    wb(1'b1, `GPT_OFF_CFG, 32'h0000_0001);
    rd_chk(`GPT_OFF_CNT_A, 32'h0000_0001);
    wb(1'b1, `GPT_OFF_MATCH, 32'h0000_0003);
    wb(1'b1, `GPT_OFF_IMR, 32'h0000_0008);
    halt <= 1'b1;
    run <= 1'b1;
    wb(1'b1, `GPT_OFF_CTL, 32'h0000_0013);
    wait_for(2, 600);
    check(32'(n > 80 && n < 110), 32'h0000_0001);
    rd_chk(`GPT_OFF_CNT_A, 32'h0000_0000);
    rd_chk(`GPT_OFF_MIS, 32'h0000_0008);
    wb(1'b1, `GPT_OFF_ICR, 32'h0000_0008);
    // Periodic timeout flag was never cleared and must survive
    rd_chk(`GPT_OFF_RIS, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    run <= 1'b0;
    halt <= 1'b0;
    wb(1'b1, `GPT_OFF_CTL, 32'h0000_0000);
    wb(1'b1, `GPT_OFF_CFG, 32'h0000_0000);
    wb(1'b1, `GPT_OFF_CFG, 32'h0000_0001);
    rd_chk(`GPT_OFF_CNT_A, 32'h0000_0003);
    $display("test clock done");
    // Two halves with different modes, then reset in mid-run
    wb(1'b1, `GPT_OFF_CFG, 32'h0000_0004);
    wb(1'b1, `GPT_OFF_MODE_A, 32'h0000_0002);
    wb(1'b1, `GPT_OFF_MODE_B, 32'h0000_0001);
    wb(1'b1, `GPT_OFF_ILR_A, 32'h0000_0005);
    wb(1'b1, `GPT_OFF_ILR_B, 32'h0000_0008);
    wb(1'b1, `GPT_OFF_PR_B, 32'h0000_0001);
    rd_chk(`GPT_OFF_ILR_A, 32'h0000_0005);
    wb(1'b1, `GPT_OFF_CTL, 32'h0000_0101);
    wait_for(1, 100);
    rd_chk(`GPT_OFF_CTL, 32'h0000_0001);
    rd_chk(`GPT_OFF_RIS, 32'h0000_0101);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`GPT_OFF_CNT_B, 32'h0000_FFFF);
    rd_chk(`GPT_OFF_CFG, 32'h0000_0000);
    $display("test halves done");
    complete_run;
  end
endmodule
`default_nettype wire
